// [scdr_pkg.sv]
// package for the socket i/o offset and card detect register block
// assumes byte-wide register access from the host-side access logic
`default_nettype none

package scdr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CARD_DETECT_OFS = 12'h816; // card detect and general control
  localparam logic [11:0] IOWIN0_LOW_OFS  = 12'h836; // i/o window 0 offset low byte
  localparam logic [11:0] IOWIN0_HIGH_OFS = 12'h837; // i/o window 0 offset high byte
  localparam logic [11:0] IOWIN1_LOW_OFS  = 12'h838; // i/o window 1 offset low byte
  localparam logic [11:0] IOWIN1_HIGH_OFS = 12'h839; // i/o window 1 offset high byte

  // ----------------------------------------------------------------
  // field positions of the card detect register
  // ----------------------------------------------------------------
  localparam int VS_B_BIT      = 7; // second voltage-sense level
  localparam int VS_A_BIT      = 6; // first voltage-sense level
  localparam int SOFT_IRQ_BIT  = 5; // software card-detect interrupt, write-only
  localparam int WAKE_EN_BIT   = 4; // card-detect wake enable
  localparam int CLR_REGS_BIT  = 1; // clear registers on removal
  localparam int OFS_EVEN_BIT  = 0; // low offset bit, always zero

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RESET  = 8'h00; // offset bytes
  localparam logic       CTRL_RESET = 1'b0;  // control bits

  // host register access bundle
  typedef struct packed {
    logic        rd;    // read strobe
    logic        wr;    // write strobe
    logic [11:0] addr;  // register offset
    logic [7:0]  wdata; // write data
  } scdr_req_s;

endpackage : scdr_pkg

`default_nettype wire

// [scdr_regs.sv]
// socket i/o window offset registers and card detect/general control
// assumes the host access logic presents synchronous byte strobes on clk,
// and that card-detect/removal/status-change inputs are synchronous levels
`default_nettype none

// Summary of operation
// - low byte holds offset bits, bit0 zero
// - high byte fully read/write, resets zero
// - two windows, each with low/high bytes
// - bit 7 returns live sense-b pin
// - bit 6 returns live sense-a pin
// - soft irq fires only when enabled
// - wake output low after change when bit4 set, until cleared or bit4 cleared
// - removal resets the offset registers when bit1 set
// - bits 3,2,0 read zero, ignore writes
module scdr_regs #(
  parameter int NUM_WIN = 2 // number of i/o windows
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // host register access
  input  wire scdr_pkg::scdr_req_s hostReq,
  output logic [7:0]              rdData,
  // socket pins
  input  wire logic               voltage_sense_a,
  input  wire logic               voltage_sense_b,
  input  wire logic               card_detect_a,
  input  wire logic               card_detect_b,
  // status-change context
  input  wire logic               cardRemoved,
  input  wire logic               cardDetectIrqEn,
  input  wire logic               cscStatusClear,
  // outputs
  output logic                    softCardDetectIrq,
  output logic                    ring_wake_out,
  output logic [15:0]             ioWinOffset [NUM_WIN]
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // map: 816 card detect/control, 836/837 window 0 low/high,
  // 838/839 window 1 low/high; every other offset reads zero
  // only bits 4 and 1 of 816 hold state; the sense bits are live pins
  // and the soft interrupt bit is a strobe, so neither needs a flop
  logic [7:0] ofsLow_q  [NUM_WIN]; // low offset bytes
  logic [7:0] ofsHigh_q [NUM_WIN]; // high offset bytes
  logic       wakeEn_q;            // card_detect_wake_enable
  logic       clrRegs_q;           // clear_regs_on_removal
  logic [1:0] cdPrev_q;            // previous card-detect levels
  logic       wakeLow_q;           // ring-wake asserted state
  logic       softIrq_q;           // soft interrupt pulse
  logic [7:0] rdData_q;            // registered read data
  logic       removalClear;        // removal wipes registers
  logic       cdChange;            // card-detect edge seen
  logic       ctrlWr;              // write to card detect register

  // removal clears only while the policy bit is set
  assign removalClear = cardRemoved && clrRegs_q;
  // any write that lands on the card detect register
  assign ctrlWr = hostReq.wr && (hostReq.addr == scdr_pkg::CARD_DETECT_OFS);
  // either detect pin moving counts as one change
  assign cdChange = ({card_detect_b, card_detect_a} != cdPrev_q);

  // ----------------------------------------------------------------
  // offset registers, one pair per window
  // ----------------------------------------------------------------
  // removal clear beats a host write in the same cycle, so a write racing
  // a card pull never leaves a stale window behind
  // window w lives at the window 0 offsets plus two per window
  for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
    localparam logic [11:0] LOW_OFS  = scdr_pkg::IOWIN0_LOW_OFS + 12'(2 * w);
    localparam logic [11:0] HIGH_OFS = scdr_pkg::IOWIN0_HIGH_OFS + 12'(2 * w);

    // low byte, bit 0 forced to zero on every write
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ofsLow_q[w] <= scdr_pkg::OFS_RESET;
      end else if (removalClear) begin
        ofsLow_q[w] <= scdr_pkg::OFS_RESET;
      end else if (hostReq.wr && hostReq.addr == LOW_OFS) begin
        ofsLow_q[w] <= {hostReq.wdata[7:1], 1'b0};
      end
    end

    // high byte, all bits writable
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ofsHigh_q[w] <= scdr_pkg::OFS_RESET;
      end else if (removalClear) begin
        ofsHigh_q[w] <= scdr_pkg::OFS_RESET;
      end else if (hostReq.wr && hostReq.addr == HIGH_OFS) begin
        ofsHigh_q[w] <= hostReq.wdata;
      end
    end

    assign ioWinOffset[w] = {ofsHigh_q[w], ofsLow_q[w]};
  end

  // ----------------------------------------------------------------
  // offset checks
  // ----------------------------------------------------------------
  // the even-offset rule must hold in every cycle, not only after writes
  chk_low_even: assert property (@(posedge clk) disable iff (!arst_n)
    ofsLow_q[0][0] == 1'b0 && ofsLow_q[NUM_WIN - 1][0] == 1'b0)
    else $error("offset low byte bit 0 not zero");

  // window 0 low byte keeps the upper seven written bits
  chk_low_write: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.wr && hostReq.addr == scdr_pkg::IOWIN0_LOW_OFS && !removalClear
    |=> ofsLow_q[0] == {$past(hostReq.wdata[7:1]), 1'b0})
    else $error("low byte did not take write");

  // window 0 high byte takes every written bit
  chk_high_write: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.wr && hostReq.addr == scdr_pkg::IOWIN0_HIGH_OFS && !removalClear
    |=> ofsHigh_q[0] == $past(hostReq.wdata))
    else $error("high byte did not take write");

  // window 1 high byte is storage of its own, apart from window 0
  chk_win1_high: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.wr && hostReq.addr == scdr_pkg::IOWIN1_HIGH_OFS && !removalClear
    |=> ofsHigh_q[NUM_WIN - 1] == $past(hostReq.wdata) && $stable(ofsHigh_q[0]))
    else $error("window 1 high byte write wrong");

  // window 1 low byte write leaves window 0 untouched
  chk_win1_low: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.wr && hostReq.addr == scdr_pkg::IOWIN1_LOW_OFS && !removalClear
    |=> ofsLow_q[NUM_WIN - 1] == {$past(hostReq.wdata[7:1]), 1'b0} && $stable(ofsLow_q[0]))
    else $error("window 1 low byte write wrong");

  // removal with the policy bit set empties both windows
  chk_removal_clear: assert property (@(posedge clk) disable iff (!arst_n)
    removalClear |=> ioWinOffset[0] == 16'h0000 && ioWinOffset[NUM_WIN - 1] == 16'h0000)
    else $error("removal did not clear offsets");

  // removal with the policy bit clear leaves the windows alone
  chk_removal_kept: assert property (@(posedge clk) disable iff (!arst_n)
    cardRemoved && !clrRegs_q && !hostReq.wr
    |=> $stable(ioWinOffset[0]) && $stable(ioWinOffset[NUM_WIN - 1]))
    else $error("removal changed offsets with clearing off");

  // ----------------------------------------------------------------
  // control bits of the card detect register
  // ----------------------------------------------------------------
  // bit 1 itself is not wiped by removal, so the policy survives the event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeEn_q  <= scdr_pkg::CTRL_RESET;
      clrRegs_q <= scdr_pkg::CTRL_RESET;
    end else if (ctrlWr) begin
      wakeEn_q  <= hostReq.wdata[scdr_pkg::WAKE_EN_BIT];
      clrRegs_q <= hostReq.wdata[scdr_pkg::CLR_REGS_BIT];
    end
  end

  // bit 5 is a strobe only: nothing is stored, so a read never sees it
  // and a write with the enable low leaves no trace to fire later
  // soft interrupt: one-cycle pulse, gated by the card-detect enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      softIrq_q <= 1'b0;
    end else begin
      softIrq_q <= ctrlWr && hostReq.wdata[scdr_pkg::SOFT_IRQ_BIT] && cardDetectIrqEn;
    end
  end
  assign softCardDetectIrq = softIrq_q;

  // ----------------------------------------------------------------
  // control checks
  // ----------------------------------------------------------------
  // a pulse needs an enabled write of 1 to bit 5 one cycle before
  chk_soft_irq: assert property (@(posedge clk) disable iff (!arst_n)
    softCardDetectIrq
    |-> $past(ctrlWr && hostReq.wdata[scdr_pkg::SOFT_IRQ_BIT] && cardDetectIrqEn))
    else $error("soft interrupt without enabled write");

  // and every such write does produce the pulse
  chk_soft_fire: assert property (@(posedge clk) disable iff (!arst_n)
    ctrlWr && hostReq.wdata[scdr_pkg::SOFT_IRQ_BIT] && cardDetectIrqEn
    |=> softCardDetectIrq)
    else $error("enabled soft interrupt write gave no pulse");

  // with the enable low the write is dropped without a pulse
  chk_soft_gated: assert property (@(posedge clk) disable iff (!arst_n)
    ctrlWr && !cardDetectIrqEn |=> !softCardDetectIrq)
    else $error("soft interrupt fired while disabled");

  // the two stored control bits take the written values
  chk_ctrl_store: assert property (@(posedge clk) disable iff (!arst_n)
    ctrlWr |=> wakeEn_q == $past(hostReq.wdata[scdr_pkg::WAKE_EN_BIT])
      && clrRegs_q == $past(hostReq.wdata[scdr_pkg::CLR_REGS_BIT]))
    else $error("control bits did not take write");

  // ----------------------------------------------------------------
  // ring-wake on card-detect change
  // ----------------------------------------------------------------
  // after reset the stored levels are zero, which differs from an empty
  // socket; the false change this gives is harmless because the wake
  // enable is also cleared by reset and only acts a write later
  // previous levels, used for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cdPrev_q <= 2'h0;
    end else begin
      cdPrev_q <= {card_detect_b, card_detect_a};
    end
  end

  // a new change wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeLow_q <= 1'b0;
    end else if (wakeEn_q && cdChange) begin
      wakeLow_q <= 1'b1;
    end else if (cscStatusClear || !wakeEn_q) begin
      wakeLow_q <= 1'b0;
    end
  end
  assign ring_wake_out = !wakeLow_q;

  // ----------------------------------------------------------------
  // wake checks
  // ----------------------------------------------------------------
  // once low, only a clear (or the enable dropping) may release it
  chk_wake_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !ring_wake_out && !cscStatusClear && wakeEn_q |=> !ring_wake_out)
    else $error("ring-wake released before clear");

  // an enabled change pulls the output low on the next cycle
  chk_wake_set: assert property (@(posedge clk) disable iff (!arst_n)
    wakeEn_q && cdChange |=> !ring_wake_out)
    else $error("ring-wake not driven low on change");

  // a clear with no fresh change releases the output next cycle
  chk_wake_release: assert property (@(posedge clk) disable iff (!arst_n)
    cscStatusClear && !(wakeEn_q && cdChange) |=> ring_wake_out)
    else $error("ring-wake not released by clear");

  // with the enable clear a change never pulls the output low
  chk_wake_off: assert property (@(posedge clk) disable iff (!arst_n)
    !wakeEn_q |=> ring_wake_out)
    else $error("ring-wake low while disabled");

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // registered so the host sees a steady byte that holds until the next read;
  // a read and a write to one register in one cycle returns the old value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 8'h00;
    end else if (hostReq.rd) begin
      case (hostReq.addr)
        scdr_pkg::CARD_DETECT_OFS: rdData_q <= {voltage_sense_b, voltage_sense_a,
                                                1'b0, wakeEn_q, 2'b00,
                                                clrRegs_q, 1'b0};
        scdr_pkg::IOWIN0_LOW_OFS:  rdData_q <= ofsLow_q[0];
        scdr_pkg::IOWIN0_HIGH_OFS: rdData_q <= ofsHigh_q[0];
        scdr_pkg::IOWIN1_LOW_OFS:  rdData_q <= ofsLow_q[NUM_WIN - 1];
        scdr_pkg::IOWIN1_HIGH_OFS: rdData_q <= ofsHigh_q[NUM_WIN - 1];
        default:                   rdData_q <= 8'h00; // unmapped reads zero
      endcase
    end
  end
  assign rdData = rdData_q;

  // ----------------------------------------------------------------
  // read checks
  // ----------------------------------------------------------------
  // the sense bits show the pins as they stood at the read edge
  chk_sense_read: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.rd && hostReq.addr == scdr_pkg::CARD_DETECT_OFS
    |=> rdData[7:6] == $past({voltage_sense_b, voltage_sense_a}))
    else $error("sense levels not reported");

  // write-only and reserved bits never read back as one
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    $past(hostReq.rd) && $past(hostReq.addr) == scdr_pkg::CARD_DETECT_OFS
    |-> rdData[5] == 1'b0 && rdData[3:2] == 2'b00 && rdData[0] == 1'b0)
    else $error("reserved or write-only bit read nonzero");

  // the two stored control bits read back where they were written
  chk_ctrl_read: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.rd && hostReq.addr == scdr_pkg::CARD_DETECT_OFS
    |=> rdData[scdr_pkg::WAKE_EN_BIT] == $past(wakeEn_q)
      && rdData[scdr_pkg::CLR_REGS_BIT] == $past(clrRegs_q))
    else $error("control bits read back wrong");

  // window 0 high byte reads back its stored value
  chk_high_read: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.rd && hostReq.addr == scdr_pkg::IOWIN0_HIGH_OFS
    |=> rdData == $past(ofsHigh_q[0]))
    else $error("high byte read wrong");

  // window 1 low byte reads from its own storage
  chk_win1_read: assert property (@(posedge clk) disable iff (!arst_n)
    hostReq.rd && hostReq.addr == scdr_pkg::IOWIN1_LOW_OFS
    |=> rdData == $past(ofsLow_q[NUM_WIN - 1]))
    else $error("window 1 low byte read wrong");

endmodule : scdr_regs

`default_nettype wire

// [scdr_card_model.sv]
// card sitting in the socket: drives the sense and card-detect pins
// assumes the bench changes the card state just after a clock edge
`default_nettype none

module scdr_card_model (
  // card state from the bench
  input  wire logic       inserted,
  input  wire logic [1:0] senseCode,
  // socket pins
  output logic            voltage_sense_a,
  output logic            voltage_sense_b,
  output logic            card_detect_a,
  output logic            card_detect_b
);
  // --------------------------------------------------------------
  // pin levels
  // --------------------------------------------------------------
  // both detect pins move together; a real card may skew them, not modelled
  assign card_detect_a   = ~inserted;
  assign card_detect_b   = ~inserted;
  assign voltage_sense_a = senseCode[0];
  assign voltage_sense_b = senseCode[1];
endmodule : scdr_card_model

`default_nettype wire

// [scdr_regs_bench.sv]
// bench for the socket offset and card detect register block
// assumes the card model above and one 125 MHz clock
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end

module scdr_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                clk, arst_n, inserted, irqEn, cscClr, removed;
  logic [1:0]          senseCode;
  scdr_pkg::scdr_req_s req;
  logic [7:0]          rdData;
  logic                vsA, vsB, cdA, cdB, irq, wake;
  logic [15:0]         ofs [2];
  int                  errors, checked;

  // --------------------------------------------------------------
  // clock and instances
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  scdr_card_model scdr_card_model_i (.inserted(inserted), .senseCode(senseCode),
    .voltage_sense_a(vsA), .voltage_sense_b(vsB), .card_detect_a(cdA), .card_detect_b(cdB));
  scdr_regs scdr_regs_i (.clk(clk), .arst_n(arst_n), .hostReq(req), .rdData(rdData),
    .voltage_sense_a(vsA), .voltage_sense_b(vsB), .card_detect_a(cdA), .card_detect_b(cdB),
    .cardRemoved(removed), .cardDetectIrqEn(irqEn), .cscStatusClear(cscClr),
    .softCardDetectIrq(irq), .ring_wake_out(wake), .ioWinOffset(ofs));

  // --------------------------------------------------------------
  // access tasks: each lets one edge pass before it drives, so a strobe
  // is never lowered and raised again in one time step
  // --------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1 req.wr = 1'b0;
  endtask : wr
  // result is checked two edges later since rdData holds until the next read
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1 req.rd = 1'b0;
    @(posedge clk);
    #1 `CHK(rdData, e)
  endtask : rd
  task automatic stop_test;
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    errors++;
    stop_test();
  end

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    {arst_n, irqEn, cscClr, removed, errors, checked} = '0;
    req = '0;
    inserted = 1'b1;
    senseCode = 2'b10;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(12'h836 + 12'(i), 8'h00);
    end
    rd(12'h816, 8'h80);
    wr(12'h816, 8'h20);
    `CHK(irq, 1'b0)
    irqEn = 1'b1;
    wr(12'h816, 8'h20);
    `CHK(irq, 1'b1)
    @(posedge clk);
    #1 `CHK(irq, 1'b0)
    wr(12'h836, 8'hFF);
    wr(12'h837, 8'hA5);
    wr(12'h838, 8'h13);
    wr(12'h839, 8'h5A);
    `CHK(ofs[0], 16'hA5FE)
    `CHK(ofs[1], 16'h5A12)
    rd(12'h836, 8'hFE);
    rd(12'h839, 8'h5A);
    rd(12'h838, 8'h12);
    rd(12'h837, 8'hA5);
    wr(12'h800, 8'hFF);
    rd(12'h800, 8'h00);
    wr(12'h816, 8'hFF);
    rd(12'h816, 8'h92);
    senseCode = 2'b01;
    rd(12'h816, 8'h52);
    // card pulled with wake enabled: output latches low until cleared
    inserted = 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(wake, 1'b0)
    repeat (3) @(posedge clk);
    #1 `CHK(wake, 1'b0)
    cscClr = 1'b1;
    @(posedge clk);
    #1 cscClr = 1'b0;
    @(posedge clk);
    #1 `CHK(wake, 1'b1)
    removed = 1'b1;
    @(posedge clk);
    #1 removed = 1'b0;
    `CHK(ofs[0], 16'h0000)
    `CHK(ofs[1], 16'h0000)
    // wake and clear-on-removal both off: nothing may react
    wr(12'h816, 8'h00);
    wr(12'h837, 8'h33);
    inserted = 1'b1;
    removed = 1'b1;
    @(posedge clk);
    #1 removed = 1'b0;
    @(posedge clk);
    #1 `CHK(wake, 1'b1)
    `CHK(ofs[0], 16'h3300)
    stop_test();
  end
endmodule : scdr_regs_bench

`undef CHK
`default_nettype wire
